// ---- common/actmon_pkg.sv ----
package actmon_pkg;

  // ----------------------------------------------------------------
  // Clock and time
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int unsigned POLL_MS     = 4;
  localparam int unsigned POLL_CYC    = POLL_MS * (CLK_HZ / 1000);
  localparam int unsigned TICK_US     = 655_360;
  localparam int unsigned TICK_CYC    = TICK_US * CYC_PER_US;
  localparam int unsigned SEC_CYC     = CLK_HZ;
  localparam int unsigned CMD_DELAY_S = 1;
  localparam int unsigned ALERT_DELAY_S = 2;
  localparam int unsigned WAKE_US     = 128;
  localparam int unsigned WAKE_CYC    = WAKE_US * CYC_PER_US;
  localparam int unsigned IGN_DEB_MS  = 50;
  localparam int unsigned IGN_DEB_CYC = IGN_DEB_MS * (CLK_HZ / 1000);
  localparam int unsigned SER_SHORT_MIN = 5;
  localparam int unsigned SER_LONG_MIN  = 20;
  localparam int unsigned SER_WARN_MIN  = 1;
  localparam int unsigned SEC_PER_MIN   = 60;

  // ----------------------------------------------------------------
  // Widths and option bits
  // ----------------------------------------------------------------
  localparam int unsigned NBUS     = 4;
  localparam int unsigned CNT_W    = 8;
  localparam int unsigned SEC_W    = 11;
  localparam int unsigned DLY_W    = 28;
  localparam logic [7:0]  CNT_MAX  = 8'hff;
  localparam logic [7:0]  CNT_ZERO = 8'h00;
  localparam int unsigned PO_MASTER   = 7;
  localparam int unsigned PO_SER_EN   = 5;
  localparam int unsigned PO_SER_LONG = 4;
  localparam int unsigned PO_SER_WARN = 3;
  localparam int unsigned PO_IGN_EN   = 2;
  localparam logic [7:0]  PO_RESET    = 8'h80;
  localparam int unsigned AM_ENABLE   = 7;
  localparam int unsigned AM_STANDBY  = 5;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STANDBY} pwr_state_t;

endpackage

// ---- rtl/rate_divider.sv ----
`timescale 1ns/1ps
`default_nettype none

module rate_divider
  import actmon_pkg::*;
#(
  parameter int unsigned DIV = 4
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clr,
  output logic      tick
);

  localparam int unsigned W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt;
  wire          at_last = (cnt == LAST);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= (clr || at_last) ? '0 : cnt + W'(1);
      tick <= at_last && !clr;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/activity_monitor_low_power.sv ----
// Operation
// - Sample every bus input at least once per 4 ms while enabled.
// - Mask sampling during own transmit; filter the sampled levels.
// - Count N means quiet time of N x 0.65536 s, within one step.
// - Count is eight bits and saturates at ff.
// - Return the count when the host sends the count query.
// - Monitor off after reset; enabled on first host bus send attempt.
// - Monitor held off while in bus monitoring mode.
// - Options allow warnings only, or no messages at all.
// - No standby entry unless power option bit 7 set; defaults to one.
// - Enter-standby command takes effect after one second.
// - Standby: outputs off, bus voltage low, standby control inverted, watch wakes.
// - Serial inactivity standby needs power option bits 7 and 5.
// - Serial timeout 5 or 20 minutes chosen by power option bit 4.
// - With bit 3, warn host one minute before serial timeout.
// - Serial timeout sends standby warning, standby two seconds later.
// - Bus inactivity standby needs monitor bits 7, 5 and power bit 7; timeout zero blocks.
// - Power bits 2 and 7: debounced ignition low warns, standby two seconds later.
// - In standby, wake on serial receive low of at least 128 us.
// - Bus activity wake armed only after all bus inputs seen quiet.
`timescale 1ns/1ps
`default_nettype none

module activity_monitor_low_power
  import actmon_pkg::*;
#(
  parameter int unsigned POLL_CYCLES = POLL_CYC,
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned SEC_CYCLES  = SEC_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned IGN_CYCLES  = IGN_DEB_CYC
) (
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic [NBUS-1:0] bus_in,
  input  wire logic            tx_active,
  input  wire logic            monitor_mode,
  input  wire logic            bus_send_attempt,
  input  wire logic            rx_in,
  input  wire logic            rx_char,
  input  wire logic            enter_standby_command,
  input  wire logic            activity_count_query,
  input  wire logic [7:0]      power_options,
  input  wire logic [7:0]      activity_monitor_options,
  input  wire logic [7:0]      activity_timeout_setting,
  input  wire logic            ignition_sense_input,
  output logic                 count_valid,
  output logic [CNT_W-1:0]     count_data,
  output logic                 activity_warning_message,
  output logic                 standby_warning_message,
  output logic                 standby,
  output logic                 outputs_off,
  output logic                 bus_voltage_ctrl,
  output logic                 standby_ctrl,
  output logic                 monitor_enabled,
  output logic                 wake_event
);

  // ----------------------------------------------------------------
  // Rate enables
  // ----------------------------------------------------------------
  logic poll_tick;
  logic cnt_tick;
  logic sec_tick;

  rate_divider #(.DIV(POLL_CYCLES)) u_poll (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clr     (1'b0),
    .tick    (poll_tick)
  );
  rate_divider #(.DIV(TICK_CYCLES)) u_cnt (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clr     (1'b0),
    .tick    (cnt_tick)
  );
  rate_divider #(.DIV(SEC_CYCLES)) u_sec (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clr     (rx_char),
    .tick    (sec_tick)
  );

  // ----------------------------------------------------------------
  // Bus sampling and filter
  // ----------------------------------------------------------------
  // A level must be seen on two polls in a row; one glitch is ignored.
  logic [NBUS-1:0] samp;
  logic [NBUS-1:0] samp_prev;
  logic [NBUS-1:0] pin_act;
  logic            armed_en;
  pwr_state_t      state;

  wire poll_en = (monitor_enabled || state == ST_STANDBY) && poll_tick;

  genvar g;
  generate
    for (g = 0; g < NBUS; g++) begin : g_pin
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          samp[g]      <= 1'b0;
          samp_prev[g] <= 1'b0;
        end else if (poll_en) begin
          samp[g]      <= bus_in[g] && !tx_active;
          samp_prev[g] <= samp[g];
        end
      end
      assign pin_act[g] = samp[g] && samp_prev[g];
    end
  endgenerate

  wire bus_active = |pin_act;
  // Quiet must come from a fresh poll; samples frozen before standby may be stale
  wire bus_quiet  = poll_en && ~|bus_in;

  // ----------------------------------------------------------------
  // Activity count
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] act_cnt;
  logic             mon_armed;

  wire cnt_sat        = (act_cnt == CNT_MAX);
  wire [CNT_W-1:0] next_act_cnt = bus_active ? CNT_ZERO
                                : (cnt_tick && !cnt_sat) ? act_cnt + CNT_W'(1)
                                : act_cnt;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mon_armed <= 1'b0;
      act_cnt   <= CNT_ZERO;
    end else begin
      mon_armed <= mon_armed || bus_send_attempt;
      act_cnt   <= monitor_enabled ? next_act_cnt : CNT_ZERO;
    end
  end

  // Count is cleared to zero one cycle after disable, so only a query in that first disabled cycle sees the old value
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_valid     <= 1'b0;
      count_data      <= CNT_ZERO;
      monitor_enabled <= 1'b0;
    end else begin
      count_valid     <= activity_count_query;
      if (activity_count_query) begin
        count_data <= act_cnt;
      end
      monitor_enabled <= (mon_armed || bus_send_attempt) && !monitor_mode
                         && state == ST_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Standby triggers
  // ----------------------------------------------------------------
  wire master   = power_options[PO_MASTER];
  wire am_out   = activity_monitor_options[AM_ENABLE]
                  && activity_timeout_setting != CNT_ZERO;
  wire am_sleep = am_out && activity_monitor_options[AM_STANDBY];
  wire bus_idle = monitor_enabled && act_cnt >= activity_timeout_setting;

  logic am_warned;
  wire  am_warn_go  = am_out && bus_idle && !am_warned;
  wire  am_sleep_go = master && am_sleep && bus_idle;

  localparam logic [SEC_W-1:0] SER_SHORT_S = SEC_W'(SER_SHORT_MIN * SEC_PER_MIN);
  localparam logic [SEC_W-1:0] SER_LONG_S  = SEC_W'(SER_LONG_MIN * SEC_PER_MIN);
  localparam logic [SEC_W-1:0] SER_WARN_S  = SEC_W'(SER_WARN_MIN * SEC_PER_MIN);

  logic [SEC_W-1:0] ser_sec;
  wire [SEC_W-1:0]  ser_limit = power_options[PO_SER_LONG] ? SER_LONG_S
                                                           : SER_SHORT_S;
  wire ser_en      = master && power_options[PO_SER_EN];
  wire ser_warn_go = ser_en && power_options[PO_SER_WARN] && sec_tick
                     && ser_sec == ser_limit - SER_WARN_S - SEC_W'(1);
  wire ser_sleep_go = ser_en && ser_sec >= ser_limit;

  // Ignition debounce: level must hold for the full window before it counts
  localparam int unsigned IGN_W = $clog2(IGN_CYCLES + 1);
  logic [IGN_W-1:0] ign_cnt;
  logic             ign_stable;
  wire ign_settled = (ign_cnt == IGN_W'(IGN_CYCLES - 1));
  wire ign_sleep_go = master && power_options[PO_IGN_EN] && !ign_stable;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ign_cnt    <= '0;
      ign_stable <= 1'b1;
    end else if (ignition_sense_input == ign_stable) begin
      ign_cnt <= '0;
    end else if (ign_settled) begin
      ign_cnt    <= '0;
      ign_stable <= ignition_sense_input;
    end else begin
      ign_cnt <= ign_cnt + IGN_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Wake detection
  // ----------------------------------------------------------------
  localparam int unsigned WK_W = $clog2(WAKE_CYCLES + 1);
  logic [WK_W-1:0] rx_low_cnt;
  logic            ign_prev;
  wire rx_wake  = (rx_low_cnt == WK_W'(WAKE_CYCLES - 1)) && !rx_in;
  wire bus_wake = armed_en && bus_active;
  wire ign_wake = ign_stable && !ign_prev;
  wire any_wake = rx_wake || bus_wake || ign_wake;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_low_cnt <= '0;
      ign_prev   <= 1'b1;
    end else begin
      ign_prev   <= ign_stable;
      rx_low_cnt <= (rx_in || state != ST_STANDBY || rx_wake) ? '0
                    : rx_low_cnt + WK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  localparam logic [DLY_W-1:0] CMD_DLY = DLY_W'(CMD_DELAY_S * SEC_CYCLES);
  localparam logic [DLY_W-1:0] ALR_DLY = DLY_W'(ALERT_DELAY_S * SEC_CYCLES);

  logic [DLY_W-1:0] dly;
  wire  alert_go = am_sleep_go || ser_sleep_go || ign_sleep_go;
  wire  dly_done = (dly == '0);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state                    <= ST_RUN;
      dly                      <= '0;
      ser_sec                  <= '0;
      am_warned                <= 1'b0;
      armed_en                 <= 1'b0;
      activity_warning_message <= 1'b0;
      standby_warning_message  <= 1'b0;
      wake_event               <= 1'b0;
    end else begin
      activity_warning_message <= (ser_warn_go || am_warn_go) && state == ST_RUN;
      standby_warning_message  <= 1'b0;
      wake_event               <= 1'b0;
      am_warned <= bus_idle ? (am_warned || am_warn_go) : 1'b0;
      if (rx_char || state == ST_STANDBY) begin
        ser_sec <= '0;
      end else if (sec_tick && ser_sec < ser_limit) begin
        ser_sec <= ser_sec + SEC_W'(1);
      end
      unique case (state)
        ST_RUN: begin
          if (master && enter_standby_command) begin
            dly   <= CMD_DLY - DLY_W'(1);
            state <= ST_WAIT;
          end else if (alert_go) begin
            standby_warning_message <= 1'b1;
            dly   <= ALR_DLY - DLY_W'(1);
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          dly <= dly - DLY_W'(!dly_done);
          if (dly_done) begin
            armed_en <= 1'b0;
            state    <= ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          // Arming waits for quiet so a manual standby on a busy bus holds
          armed_en <= armed_en || bus_quiet;
          if (any_wake) begin
            wake_event <= 1'b1;
            state      <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin states
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      standby          <= 1'b0;
      outputs_off      <= 1'b0;
      bus_voltage_ctrl <= 1'b1;
      standby_ctrl     <= 1'b0;
    end else begin
      standby          <= state == ST_STANDBY;
      outputs_off      <= state == ST_STANDBY;
      bus_voltage_ctrl <= state != ST_STANDBY;
      standby_ctrl     <= state == ST_STANDBY;
    end
  end

endmodule

`default_nettype wire

// ---- verif/activity_monitor_low_power_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module amlp_props (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       monitor_mode,
  input wire logic       rx_in,
  input wire logic       enter_standby_command,
  input wire logic       activity_count_query,
  input wire logic [7:0] power_options,
  input wire logic       count_valid,
  input wire logic [7:0] count_data,
  input wire logic       standby_warning_message,
  input wire logic       standby,
  input wire logic       outputs_off,
  input wire logic       bus_voltage_ctrl,
  input wire logic       standby_ctrl,
  input wire logic       monitor_enabled,
  input wire logic       wake_event
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Delays assume the shortened second of 50 cycles
  // ----------------------------------------------------------------
  a_query_answer: assert property (activity_count_query |=> count_valid)
    else $error("count query not answered");
  a_valid_only: assert property (!activity_count_query |=> !count_valid)
    else $error("count answer without query");
  a_count_idle: assert property (
    !monitor_enabled [*3] ##0 activity_count_query |=> count_data == 8'h00)
    else $error("count not zero while monitor off");
  a_mode_hold: assert property (monitor_mode [*2] |-> !monitor_enabled)
    else $error("monitor on in monitoring mode");
  a_master_gate: assert property ($rose(standby) |-> power_options[7])
    else $error("standby without master enable");
  a_cmd_delay: assert property (
    enter_standby_command && power_options[7] && !standby |-> ##52 standby)
    else $error("standby command delay wrong");
  a_standby_pins: assert property (outputs_off == standby &&
    bus_voltage_ctrl == !standby && standby_ctrl == standby)
    else $error("standby pin states wrong");
  a_warn_delay: assert property (standby_warning_message |-> ##101 standby)
    else $error("standby not two seconds after warning");
  a_rx_wake: assert property (
    standby && $fell(rx_in) ##1 !rx_in [*8] |-> ##[0:3] wake_event)
    else $error("long receive low did not wake");
endmodule

bind activity_monitor_low_power amlp_props props (.sys_clk, .rst, .monitor_mode, .rx_in,
  .enter_standby_command, .activity_count_query, .power_options, .count_valid, .count_data,
  .standby_warning_message, .standby, .outputs_off, .bus_voltage_ctrl, .standby_ctrl,
  .monitor_enabled, .wake_event);

`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic sys_clk,
  output logic      rx_in,
  output logic      rx_char,
  output logic      cmd,
  output logic      query,
  output logic      attempt
);
  initial begin
    {rx_char, cmd, query, attempt} = 4'h0;
    rx_in = 1'b1;
  end

  // ----------------------------------------------------------------
  // One-cycle requests, moved only on falling edges
  // ----------------------------------------------------------------
  task automatic hit(input int k);
    @(negedge sys_clk);
    {rx_char, cmd, query, attempt} = 4'h8 >> k;
    @(negedge sys_clk);
    {rx_char, cmd, query, attempt} = 4'h0;
  endtask

  // Line idles high; a break shorter than the wake width must be ignored
  task automatic brk(input int n);
    @(negedge sys_clk);
    rx_in = 1'b0;
    repeat (n) @(negedge sys_clk);
    rx_in = 1'b1;
  endtask
endmodule

`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
  import actmon_pkg::*;
  logic            sys_clk, rst, tx_active, monitor_mode, rx_in, rx_char;
  logic            enter_standby_command, activity_count_query, bus_send_attempt;
  logic [NBUS-1:0] bus_in;
  logic [7:0]      power_options, activity_monitor_options, activity_timeout_setting;
  logic [7:0]      count_data, opt [2];
  logic            ignition_sense_input, count_valid, activity_warning_message, standby;
  logic            standby_warning_message, outputs_off, bus_voltage_ctrl, standby_ctrl;
  logic            monitor_enabled, wake_event;
  int              fails, total_checks, n_act, n_lp, n_wk, c, k;

  activity_monitor_low_power #(.POLL_CYCLES(10), .TICK_CYCLES(20), .SEC_CYCLES(50),
    .WAKE_CYCLES(8), .IGN_CYCLES(4)) dut (.sys_clk, .rst, .bus_in, .tx_active,
    .monitor_mode, .bus_send_attempt, .rx_in, .rx_char, .enter_standby_command,
    .activity_count_query, .power_options, .activity_monitor_options,
    .activity_timeout_setting, .ignition_sense_input, .count_valid, .count_data,
    .activity_warning_message, .standby_warning_message, .standby, .outputs_off,
    .bus_voltage_ctrl, .standby_ctrl, .monitor_enabled, .wake_event);
  host_model host (.sys_clk, .rx_in, .rx_char, .cmd(enter_standby_command),
    .query(activity_count_query), .attempt(bus_send_attempt));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Pulses are counted here so that missing or extra messages show later
  always @(posedge sys_clk) begin
    n_act += int'(activity_warning_message === 1'b1);
    n_lp += int'(standby_warning_message === 1'b1);
    n_wk += int'(wake_event === 1'b1);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: got %0h want %0h..%0h", $time, got, lo, hi);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wt(ref logic s, input int n, output int cnt);
    cnt = 0;
    while (s !== 1'b1 && cnt < n) begin
      @(negedge sys_clk);
      cnt++;
    end
    if (s !== 1'b1) begin
      fails++;
      results();
    end
  endtask

  task automatic q(input logic [7:0] lo, input logic [7:0] hi);
    host.hit(2);
    chk(32'(count_valid), 1, 1);
    chk(32'(count_data), 32'(lo), 32'(hi));
    @(negedge sys_clk);
    chk(32'(count_valid), 0, 0);
  endtask

  function automatic logic [NBUS-1:0] act();
    return NBUS'($urandom_range(15, 1));
  endfunction

  // Unused option bits are randomised; the design must ignore them
  function automatic logic [7:0] rnd(input logic [7:0] b, input logic [7:0] m);
    return b | (8'($urandom) & m);
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(39));
    {tx_active, monitor_mode, ignition_sense_input, rst} = 4'h3;
    bus_in = 4'h0;
    opt = '{8'h80, 8'ha0};
    power_options = PO_RESET;
    activity_monitor_options = 8'h00;
    activity_timeout_setting = 8'h05;
    cyc(10);
    rst = 1'b0;
    chk({monitor_enabled, standby, outputs_off, standby_ctrl, bus_voltage_ctrl}, 1, 1);
    cyc(100);
    q(8'h00, 8'h00);
    host.hit(3);
    @(negedge sys_clk);
    chk(32'(monitor_enabled), 1, 1);
    cyc(200);
    q(8'h09, 8'h0b);
    bus_in = act();
    tx_active = 1'b1;
    cyc(200);
    q(8'h12, 8'h17);
    tx_active = 1'b0;
    cyc(40);
    q(8'h00, 8'h01);
    for (int i = 0; i < NBUS; i++) begin
      bus_in = 4'h0;
      cyc($urandom_range(120, 60));
      bus_in = NBUS'(1 << i);
      cyc(40);
      q(8'h00, 8'h01);
    end
    bus_in = 4'h0;
    tx_active = 1'($urandom);
    cyc(5400);
    q(8'hff, 8'hff);
    tx_active = 1'b0;
    chk(n_act, 0, 0);
    monitor_mode = 1'b1;
    cyc(3);
    chk(32'(monitor_enabled), 0, 0);
    host.hit(3);
    cyc(3);
    q(8'h00, 8'h00);
    monitor_mode = 1'b0;
    power_options = 8'h00;
    host.hit(1);
    cyc(80);
    chk(32'(standby), 0, 0);
    power_options = rnd(PO_RESET, 8'h43);
    bus_in = act();
    host.hit(1);
    wt(standby, 70, c);
    chk(c, 51, 53);
    chk({outputs_off, bus_voltage_ctrl, standby_ctrl}, 5, 5);
    host.brk(4);
    cyc(40);
    chk(32'(standby), 1, 1);
    k = n_wk;
    host.brk(12);
    cyc(5);
    chk(n_wk, k + 1, k + 1);
    chk({outputs_off, bus_voltage_ctrl, standby_ctrl}, 2, 2);
    host.hit(3);
    {activity_timeout_setting, activity_monitor_options} = 16'h00a0;
    bus_in = 4'h0;
    k = n_act;
    cyc(400);
    chk(n_act, k, k);
    activity_monitor_options = 8'h00;
    activity_timeout_setting = 8'($urandom_range(6, 3));
    foreach (opt[i]) begin
      bus_in = act();
      cyc(40);
      activity_monitor_options = rnd(opt[i], 8'h5f);
      bus_in = 4'h0;
      wt(activity_warning_message, 200, c);
      chk(c, 20 * activity_timeout_setting - 20, 20 * activity_timeout_setting + 15);
      k = n_lp;
      if (opt[i][AM_STANDBY]) begin
        wt(standby, 200, c);
        chk(c, 100, 102);
        cyc(20);
        bus_in = act();
        wt(wake_event, 100, c);
        bus_in = 4'h0;
        host.hit(3);
      end else begin
        cyc(200);
        chk(n_lp, k, k);
      end
    end
    activity_monitor_options = 8'h00;
    power_options = rnd(8'h84, 8'h43);
    ignition_sense_input = 1'b0;
    wt(standby, 300, c);
    chk(c, 100, 115);
    ignition_sense_input = 1'b1;
    wt(wake_event, 100, c);
    power_options = rnd(8'ha8, 8'h43);
    host.hit(0);
    cyc(5000);
    host.hit(0);
    wt(activity_warning_message, 13000, c);
    chk(c, 11880, 12010);
    wt(standby_warning_message, 3200, c);
    chk(c, 2990, 3110);
    wt(standby, 120, c);
    chk(c, 98, 104);
    host.brk(12);
    foreach (opt[i]) begin
      power_options = rnd(i ? 8'h28 : 8'hb8, 8'h43);
      k = n_act + n_lp;
      host.hit(0);
      cyc(15100);
      chk(n_act + n_lp, k, k);
    end
    results();
  end
endmodule

`default_nettype wire
